// >>> src/sflash_rd_front.sv
// Purpose: read-command front end of a serial flash slave
// Assumes: array answers within the same I_CLOCK cycle as O_ARRAY_RD
// Notes:   link logic on I_SCLK, array fetch on I_CLOCK
`timescale 1ns/1ns
// Operation
// - opcode 03h then 24-bit address, rising edge
// - data bytes out MSB first, falling edges
// - address increments per byte until deselect
// - plain read ignored while write in progress
// - plain read only in single-line mode
// - fast read: eight dummy clocks, input ignored
// - four-wire mode dummy count 2/4/6/8 selectable
// - 3Bh: eight dummies, data on two lines
// - 6Bh: quad data, needs quad enable
// - BBh: address and data two bits/clock
// - mode bits after address, only bits 5:4 used
// - dual: mode 10 skips next opcode
// - quad: mode 10 skips next opcode
// - EBh: quad address/data, four dummies, enable
// - wrap within aligned section of page
// - wrap disable and length held for reads
// - four-wire mode: mode bits count as dummies
// - no wrap in four-wire mode
// - disable bit 1 default, lengths 8..64
// - 77h, 24 dummy bits, wrap bits 6:4
// - quad byte: bits 7:4 then 3:0
module sflash_rd_front (
   // system clock and reset
   input  wire logic        I_CLOCK,
   input  wire logic        I_RST,
   // link from the host
   input  wire logic        I_SCLK,
   input  wire logic        I_CHIP_SELECT_N,
   input  wire logic [3:0]  I_IO_LINE,
   output logic      [3:0]  O_IO_LINE,
   output logic      [3:0]  O_IO_LINE_OE_N,
   // configuration from the core
   input  wire logic        I_WRITE_IN_PROGRESS,
   input  wire logic        I_QUAD_ENABLE,
   input  wire logic        I_FOUR_WIRE_MODE,
   input  wire logic [1:0]  I_DUMMY_COUNT_FIELD,
   // array read port
   output logic             O_ARRAY_RD,
   output logic      [23:0] O_ARRAY_ADDR,
   input  wire logic [7:0]  I_ARRAY_DATA
);
   // per-frame state, cleared by deselect
   typedef struct packed {
      sflash_rd_pkg::link_st_t st;
      sflash_rd_pkg::kind_t    kind;
      logic [4:0]              cnt;
      logic [3:0]              dneed;
      logic [2:0]              dcnt;
      logic [23:0]             sr;
      logic [23:0]             addr;
   } lnk_t;
   // link state that outlives a frame
   typedef struct packed {
      logic [1:0] wip_sy;
      logic [1:0] qe_sy;
      logic [1:0] qpi_sy;
      logic [1:0] dsel_s1;
      logic [1:0] dsel_s2;
      logic       req_tog;
      logic       cont;
      logic       cont_quad;
      logic       wrap_dis;
      logic [1:0] wrap_len;
   } per_t;
   // falling-edge output stage
   typedef struct packed {
      logic [7:0] sh;
      logic [3:0] io;
      logic [3:0] oe_n;
   } neg_t;
   // array fetch on the system clock
   typedef struct packed {
      logic [2:0]  tog_sy;
      logic        rd;
      logic [23:0] addr;
      logic [7:0]  data;
   } core_t;

   lnk_t                    lnk_ff, nxt_lnk;
   per_t                    per_ff, nxt_per;
   neg_t                    neg_ff, nxt_neg;
   core_t                   core_ff, nxt_core;
   logic                    frame_rst;
   sflash_rd_pkg::link_st_t st_e;
   sflash_rd_pkg::kind_t    kind_e;
   logic [2:0]              win;
   logic [2:0]              wout;
   logic [4:0]              need;
   logic                    last;
   logic [23:0]             shifted;
   logic                    write_in_progress;
   logic                    qe;
   logic                    four_wire_command_mode;
   logic [3:0]              qpi_dummy;
   logic                    wrap_on;
   logic [7:0]              nb;

   // clocks needed to move a number of bits over w lanes
   function automatic logic [4:0] clks(input logic [4:0] bits, input logic [2:0] w);
      if (w == sflash_rd_pkg::LANE_4) begin
         return bits >> 2;
      end else if (w == sflash_rd_pkg::LANE_2) begin
         return bits >> 1;
      end
      return bits;
   endfunction

   // next byte address, wrapping inside the section when asked
   function automatic logic [23:0] step_addr(input logic [23:0] a, input logic wrap,
                                             input logic [1:0] len);
      logic [7:0] m;
      m = (sflash_rd_pkg::WRAP_MIN_SECT << len) - 8'h01;
      if (wrap) begin
         return {a[23:8], (a[7:0] & ~m) | ((a[7:0] + 8'h01) & m)};
      end
      return a + 24'h000001;
   endfunction

   // deselect ends the frame at once; sclk may stop right after
   assign frame_rst = I_RST | I_CHIP_SELECT_N;

   // link decode, one step per rising sclk edge
   always_comb begin
      nxt_lnk = lnk_ff;
      nxt_per = per_ff;
      // config levels from the core cross on two flops
      nxt_per.wip_sy  = {per_ff.wip_sy[0], I_WRITE_IN_PROGRESS};
      nxt_per.qe_sy   = {per_ff.qe_sy[0], I_QUAD_ENABLE};
      nxt_per.qpi_sy  = {per_ff.qpi_sy[0], I_FOUR_WIRE_MODE};
      nxt_per.dsel_s1 = I_DUMMY_COUNT_FIELD;
      nxt_per.dsel_s2 = per_ff.dsel_s1;
      write_in_progress = per_ff.wip_sy[1];
      qe  = per_ff.qe_sy[1];
      four_wire_command_mode = per_ff.qpi_sy[1];
      qpi_dummy = {1'h0, per_ff.dsel_s2, 1'h0} + 4'h2;
      // a frame in continuous mode opens with the address
      st_e   = lnk_ff.st;
      kind_e = lnk_ff.kind;
      if (lnk_ff.st == sflash_rd_pkg::ST_START) begin
         st_e = per_ff.cont ? sflash_rd_pkg::ST_ADDR : sflash_rd_pkg::ST_OPC;
         kind_e = per_ff.cont_quad ? sflash_rd_pkg::K_QIO : sflash_rd_pkg::K_DIO;
      end
      // input lanes of the current phase
      win = sflash_rd_pkg::LANE_1;
      if (four_wire_command_mode) begin
         win = sflash_rd_pkg::LANE_4;
      end else if (st_e != sflash_rd_pkg::ST_OPC) begin
         if (kind_e == sflash_rd_pkg::K_DIO) begin
            win = sflash_rd_pkg::LANE_2;
         end else if (kind_e == sflash_rd_pkg::K_QIO || kind_e == sflash_rd_pkg::K_WRAP) begin
            win = sflash_rd_pkg::LANE_4;
         end
      end
      // output lanes; four-wire mode always answers on four
      wout = sflash_rd_pkg::LANE_1;
      if (four_wire_command_mode || kind_e == sflash_rd_pkg::K_QOUT || kind_e == sflash_rd_pkg::K_QIO) begin
         wout = sflash_rd_pkg::LANE_4;
      end else if (kind_e == sflash_rd_pkg::K_DOUT || kind_e == sflash_rd_pkg::K_DIO) begin
         wout = sflash_rd_pkg::LANE_2;
      end
      wrap_on = kind_e == sflash_rd_pkg::K_QIO && !four_wire_command_mode && !per_ff.wrap_dis;
      // msb first shift of the sampled lanes
      unique case (win)
         sflash_rd_pkg::LANE_4: shifted = {lnk_ff.sr[19:0], I_IO_LINE};
         sflash_rd_pkg::LANE_2: shifted = {lnk_ff.sr[21:0], I_IO_LINE[1:0]};
         default:               shifted = {lnk_ff.sr[22:0], I_IO_LINE[0]};
      endcase
      // clocks in the current phase
      unique case (st_e)
         sflash_rd_pkg::ST_OPC:   need = clks(sflash_rd_pkg::OPC_BITS, win);
         sflash_rd_pkg::ST_ADDR:  need = clks(sflash_rd_pkg::ADDR_BITS, win);
         sflash_rd_pkg::ST_MODE:  need = clks(sflash_rd_pkg::MODE_BITS, win);
         sflash_rd_pkg::ST_WRAP:  need = clks(sflash_rd_pkg::WRAP_BITS, win);
         sflash_rd_pkg::ST_DUMMY: need = {1'h0, lnk_ff.dneed};
         default:                 need = 5'h01;
      endcase
      last = lnk_ff.cnt == need - 5'h01;
      nxt_lnk.st   = st_e;
      nxt_lnk.kind = kind_e;
      nxt_lnk.sr   = shifted;
      nxt_lnk.cnt  = last ? 5'h00 : lnk_ff.cnt + 5'h01;
      unique case (st_e)
         // instruction byte; refused ones idle until deselect
         sflash_rd_pkg::ST_OPC: begin
            if (last) begin
               nxt_lnk.st = sflash_rd_pkg::ST_ADDR;
               unique case (shifted[7:0])
                  sflash_rd_pkg::OPC_READ: begin
                     nxt_lnk.kind = sflash_rd_pkg::K_READ;
                     if (write_in_progress || four_wire_command_mode) begin
                        nxt_lnk.st = sflash_rd_pkg::ST_IGNORE;
                     end
                  end
                  sflash_rd_pkg::OPC_FAST: begin
                     nxt_lnk.kind = sflash_rd_pkg::K_FAST;
                     if (write_in_progress) begin
                        nxt_lnk.st = sflash_rd_pkg::ST_IGNORE;
                     end
                  end
                  sflash_rd_pkg::OPC_DUAL_OUT: begin
                     nxt_lnk.kind = sflash_rd_pkg::K_DOUT;
                     if (write_in_progress || four_wire_command_mode) begin
                        nxt_lnk.st = sflash_rd_pkg::ST_IGNORE;
                     end
                  end
                  sflash_rd_pkg::OPC_QUAD_OUT: begin
                     nxt_lnk.kind = sflash_rd_pkg::K_QOUT;
                     if (write_in_progress || four_wire_command_mode || !qe) begin
                        nxt_lnk.st = sflash_rd_pkg::ST_IGNORE;
                     end
                  end
                  sflash_rd_pkg::OPC_DUAL_IO: begin
                     nxt_lnk.kind = sflash_rd_pkg::K_DIO;
                     if (write_in_progress || four_wire_command_mode) begin
                        nxt_lnk.st = sflash_rd_pkg::ST_IGNORE;
                     end
                  end
                  sflash_rd_pkg::OPC_QUAD_IO: begin
                     nxt_lnk.kind = sflash_rd_pkg::K_QIO;
                     if (write_in_progress || !qe) begin
                        nxt_lnk.st = sflash_rd_pkg::ST_IGNORE;
                     end
                  end
                  sflash_rd_pkg::OPC_SET_WRAP: begin
                     nxt_lnk.kind = sflash_rd_pkg::K_WRAP;
                     if (four_wire_command_mode) begin
                        nxt_lnk.st = sflash_rd_pkg::ST_IGNORE;
                     end
                  end
                  default: nxt_lnk.st = sflash_rd_pkg::ST_IGNORE;
               endcase
            end
         end
         // address; set-wrap takes these clocks as dummies
         sflash_rd_pkg::ST_ADDR: begin
            if (last) begin
               nxt_lnk.addr = shifted;
               nxt_lnk.dneed = four_wire_command_mode ? qpi_dummy : sflash_rd_pkg::SPI_DUMMY_CLKS;
               unique case (kind_e)
                  sflash_rd_pkg::K_READ: nxt_lnk.st = sflash_rd_pkg::ST_DATA;
                  sflash_rd_pkg::K_DIO:  nxt_lnk.st = sflash_rd_pkg::ST_MODE;
                  sflash_rd_pkg::K_QIO:  nxt_lnk.st = sflash_rd_pkg::ST_MODE;
                  sflash_rd_pkg::K_WRAP: nxt_lnk.st = sflash_rd_pkg::ST_WRAP;
                  default:               nxt_lnk.st = sflash_rd_pkg::ST_DUMMY;
               endcase
               // first fetch starts now to meet the first falling edge
               if (kind_e != sflash_rd_pkg::K_WRAP) begin
                  nxt_per.req_tog = ~per_ff.req_tog;
               end
            end
         end
         // mode bits; only bits 5:4 matter
         sflash_rd_pkg::ST_MODE: begin
            if (last) begin
               nxt_per.cont      = shifted[5:4] == sflash_rd_pkg::CONT_CODE;
               nxt_per.cont_quad = kind_e == sflash_rd_pkg::K_QIO;
               nxt_lnk.st = sflash_rd_pkg::ST_DATA;
               if (kind_e == sflash_rd_pkg::K_QIO) begin
                  if (!four_wire_command_mode) begin
                     nxt_lnk.dneed = sflash_rd_pkg::QIO_DUMMY_CLKS;
                     nxt_lnk.st = sflash_rd_pkg::ST_DUMMY;
                  end else if (qpi_dummy > {1'h0, need[2:0]}) begin
                     // mode clocks already spent part of the dummies
                     nxt_lnk.dneed = qpi_dummy - {1'h0, need[2:0]};
                     nxt_lnk.st = sflash_rd_pkg::ST_DUMMY;
                  end
               end
            end
         end
         // dummy clocks; lane values are not used
         sflash_rd_pkg::ST_DUMMY: begin
            if (last) begin
               nxt_lnk.st = sflash_rd_pkg::ST_DATA;
            end
         end
         // data; fetch the next byte once the current one is loaded
         sflash_rd_pkg::ST_DATA: begin
            nxt_lnk.dcnt = (lnk_ff.dcnt == 3'(clks(5'h08, wout) - 5'h01)) ? 3'h0 : lnk_ff.dcnt + 3'h1;
            if (lnk_ff.dcnt == 3'h0) begin
               nxt_lnk.addr = step_addr(lnk_ff.addr, wrap_on, per_ff.wrap_len);
               nxt_per.req_tog = ~per_ff.req_tog;
            end
         end
         // wrap bits; taken only when the byte is complete
         sflash_rd_pkg::ST_WRAP: begin
            if (last) begin
               nxt_per.wrap_dis = shifted[sflash_rd_pkg::WRAP_DIS_POS];
               nxt_per.wrap_len = shifted[sflash_rd_pkg::WRAP_LEN_LSB +: 2];
               nxt_lnk.st = sflash_rd_pkg::ST_IGNORE;
            end
         end
         default: nxt_lnk.st = sflash_rd_pkg::ST_IGNORE;
      endcase
   end

   // frame registers
   always_ff @(posedge I_SCLK or posedge frame_rst) begin
      if (frame_rst) begin
         lnk_ff <= '{st: sflash_rd_pkg::ST_START, kind: sflash_rd_pkg::K_READ, default: '0};
      end else begin
         lnk_ff <= nxt_lnk;
      end
   end

   // settings kept across frames
   always_ff @(posedge I_SCLK or posedge I_RST) begin
      if (I_RST) begin
         per_ff <= '{wrap_dis: sflash_rd_pkg::WRAP_DIS_RST, wrap_len: sflash_rd_pkg::WRAP_LEN_RST,
                     default: '0};
      end else begin
         per_ff <= nxt_per;
      end
   end

   // output stage: load fetched byte or shift by lane width
   always_comb begin
      nxt_neg = neg_ff;
      nb = neg_ff.sh;
      nxt_neg.oe_n = 4'hF;
      nxt_neg.io = 4'h0;
      if (lnk_ff.st == sflash_rd_pkg::ST_DATA) begin
         // core data is stable: its fetch was asked at least half an sclk earlier
         nb = (lnk_ff.dcnt == 3'h0) ? core_ff.data : neg_ff.sh << wout;
         unique case (wout)
            sflash_rd_pkg::LANE_4: begin
               nxt_neg.io = nb[7:4];
               nxt_neg.oe_n = 4'h0;
            end
            sflash_rd_pkg::LANE_2: begin
               nxt_neg.io = {2'h0, nb[7:6]};
               nxt_neg.oe_n = 4'hC;
            end
            default: begin
               nxt_neg.io = {2'h0, nb[7], 1'h0};
               nxt_neg.oe_n = 4'hD;
            end
         endcase
      end
      nxt_neg.sh = nb;
   end

   // pins change on falling sclk edges
   always_ff @(negedge I_SCLK or posedge frame_rst) begin
      if (frame_rst) begin
         neg_ff <= '{oe_n: 4'hF, default: '0};
      end else begin
         neg_ff <= nxt_neg;
      end
   end

   // fetch request toggle crosses on two flops, then edge detect
   always_comb begin
      nxt_core = core_ff;
      nxt_core.tog_sy = {core_ff.tog_sy[1:0], per_ff.req_tog};
      nxt_core.rd = core_ff.tog_sy[2] ^ core_ff.tog_sy[1];
      if (core_ff.tog_sy[2] ^ core_ff.tog_sy[1]) begin
         nxt_core.addr = lnk_ff.addr; // held since the toggle
      end
      if (core_ff.rd) begin
         nxt_core.data = I_ARRAY_DATA;
      end
   end

   // system clock registers
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         core_ff <= '0;
      end else begin
         core_ff <= nxt_core;
      end
   end

   assign O_IO_LINE      = neg_ff.io;
   assign O_IO_LINE_OE_N = neg_ff.oe_n;
   assign O_ARRAY_RD     = core_ff.rd;
   assign O_ARRAY_ADDR   = core_ff.addr;
endmodule // sflash_rd_front

// >>> src/sflash_rd_pkg.sv
// Purpose: shared constants and types of the serial flash read front end
// Assumes: byte-wide array behind a 24-bit address
// Notes:   opcodes, phase lengths and wrap defaults live here
package sflash_rd_pkg;
   // instruction codes
   localparam logic [7:0] OPC_READ     = 8'h03;
   localparam logic [7:0] OPC_FAST     = 8'h0B;
   localparam logic [7:0] OPC_DUAL_OUT = 8'h3B;
   localparam logic [7:0] OPC_QUAD_OUT = 8'h6B;
   localparam logic [7:0] OPC_DUAL_IO  = 8'hBB;
   localparam logic [7:0] OPC_QUAD_IO  = 8'hEB;
   localparam logic [7:0] OPC_SET_WRAP = 8'h77;
   // phase lengths in bits or clocks
   localparam logic [4:0] OPC_BITS       = 5'h08;
   localparam logic [4:0] ADDR_BITS      = 5'h18;
   localparam logic [4:0] MODE_BITS      = 5'h08;
   localparam logic [4:0] WRAP_BITS      = 5'h08;
   localparam logic [3:0] SPI_DUMMY_CLKS = 4'h8;
   localparam logic [3:0] QIO_DUMMY_CLKS = 4'h4;
   // continuous read code in mode bits 5:4
   localparam logic [1:0] CONT_CODE = 2'h2;
   // wrap field positions and defaults
   localparam int         WRAP_DIS_POS  = 4;
   localparam int         WRAP_LEN_LSB  = 5;
   localparam logic       WRAP_DIS_RST  = 1'h1;
   localparam logic [1:0] WRAP_LEN_RST  = 2'h0;
   localparam logic [7:0] WRAP_MIN_SECT = 8'h08;
   // lane widths
   localparam logic [2:0] LANE_1 = 3'h1;
   localparam logic [2:0] LANE_2 = 3'h2;
   localparam logic [2:0] LANE_4 = 3'h4;
   // instruction phases seen on the link
   typedef enum logic [2:0] {
      ST_START, ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_WRAP, ST_IGNORE
   } link_st_t;
   // accepted instruction kinds
   typedef enum logic [2:0] {
      K_READ, K_FAST, K_DOUT, K_QOUT, K_DIO, K_QIO, K_WRAP
   } kind_t;
endpackage

// >>> dv/sflash_rd_front_chk.sv
// Purpose: assertions on the read front end ports
// Assumes: host moves select only while the link clock is low
// Notes:   steady-config counters run on the link clock
`timescale 1ns/1ns
module sflash_rd_front_chk (
   // clocks and reset
   input wire logic        I_CLOCK,
   input wire logic        I_RST,
   input wire logic        I_SCLK,
   // link
   input wire logic        I_CHIP_SELECT_N,
   input wire logic [3:0]  O_IO_LINE,
   input wire logic [3:0]  O_IO_LINE_OE_N,
   // configuration
   input wire logic        I_WRITE_IN_PROGRESS,
   input wire logic        I_QUAD_ENABLE,
   input wire logic        I_FOUR_WIRE_MODE,
   // array port
   input wire logic        O_ARRAY_RD,
   input wire logic [23:0] O_ARRAY_ADDR
);
   logic [2:0] busy_ff;
   logic [2:0] noquad_ff;
   logic [2:0] fourw_ff;
   // saturating count of rises with a level held; sync needs two, seven leaves margin
   function automatic logic [2:0] sat(input logic en, input logic [2:0] c);
      return !en ? 3'h0 : (c == 3'h7) ? c : c + 3'h1;
   endfunction
   // steady-level counters
   always_ff @(posedge I_SCLK or posedge I_RST) begin
      if (I_RST) begin
         busy_ff   <= 3'h0;
         noquad_ff <= 3'h0;
         fourw_ff  <= 3'h0;
      end else begin
         busy_ff   <= sat(I_WRITE_IN_PROGRESS, busy_ff);
         noquad_ff <= sat(!I_QUAD_ENABLE, noquad_ff);
         fourw_ff  <= sat(I_FOUR_WIRE_MODE, fourw_ff);
      end
   end
   a_fetch_pulse: assert property (@(posedge I_CLOCK) disable iff (I_RST)
      O_ARRAY_RD |=> !O_ARRAY_RD) else $error("fetch strobe longer than one cycle");
   a_addr_hold: assert property (@(posedge I_CLOCK) disable iff (I_RST)
      !O_ARRAY_RD |-> $stable(O_ARRAY_ADDR)) else $error("fetch address moved without a strobe");
   a_cs_release: assert property (@(posedge I_CLOCK) disable iff (I_RST)
      I_CHIP_SELECT_N |-> O_IO_LINE_OE_N == 4'hF) else $error("lanes driven while deselected");
   a_lane_legal: assert property (@(posedge I_CLOCK) disable iff (I_RST)
      O_IO_LINE_OE_N inside {4'hF, 4'hD, 4'hC, 4'h0}) else $error("illegal lane enable set");
   a_out_stand: assert property (@(posedge I_CLOCK) disable iff (I_RST)
      I_SCLK && !I_CHIP_SELECT_N |-> $stable(O_IO_LINE) && $stable(O_IO_LINE_OE_N))
      else $error("lane output changed while link clock high");
   a_busy_quiet: assert property (@(posedge I_SCLK) disable iff (I_RST)
      busy_ff == 3'h7 |-> O_IO_LINE_OE_N == 4'hF) else $error("read answered while write busy");
   a_quad_gate: assert property (@(posedge I_SCLK) disable iff (I_RST)
      noquad_ff == 3'h7 |-> O_IO_LINE_OE_N[3:2] == 2'h3) else $error("upper lanes driven without quad enable");
   a_fourw_lanes: assert property (@(posedge I_SCLK) disable iff (I_RST)
      fourw_ff == 3'h7 |-> O_IO_LINE_OE_N inside {4'hF, 4'h0}) else $error("narrow lanes in four-wire mode");
endmodule // sflash_rd_front_chk
bind sflash_rd_front sflash_rd_front_chk i_chk (
   .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_SCLK(I_SCLK), .I_CHIP_SELECT_N(I_CHIP_SELECT_N),
   .O_IO_LINE(O_IO_LINE), .O_IO_LINE_OE_N(O_IO_LINE_OE_N), .I_WRITE_IN_PROGRESS(I_WRITE_IN_PROGRESS),
   .I_QUAD_ENABLE(I_QUAD_ENABLE), .I_FOUR_WIRE_MODE(I_FOUR_WIRE_MODE), .O_ARRAY_RD(O_ARRAY_RD),
   .O_ARRAY_ADDR(O_ARRAY_ADDR));

// >>> dv/flash_host.sv
// Purpose: behavioural host controller driving the flash link
// Assumes: link clock idles low and stands still between frames
// Notes:   each received byte is flagged with whether the device drove its lanes
`timescale 1ns/1ns
module flash_host (
   // link to the device
   output logic            o_sclk,
   output logic            o_cs_n,
   output logic [3:0]      o_io,
   input  wire logic [3:0] i_dev_io,
   input  wire logic [3:0] i_dev_oe_n
);
   logic [3:0] drv = 4'h0;
   logic [3:0] val = 4'h0;
   logic [3:0] junk = 4'h5;
   logic [8:0] rx;
   logic [8:0] rx_byte;
   event       got;
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
   end
   // released lanes wander so a stale level never passes for data
   always @(posedge o_sclk) junk <= {junk[2:0], ~junk[3]};
   always_comb for (int k = 0; k < 4; k++) o_io[k] = !i_dev_oe_n[k] ? i_dev_io[k] : drv[k] ? val[k] : junk[k];
   // one link clock; lanes let go mid-high so the next fall finds them free
   task automatic tick(input logic rel, input int dl);
      logic [3:0] m;
      m = (dl == 4) ? 4'hF : (dl == 2) ? 4'h3 : 4'h2;
      #40 o_sclk = 1'b1;
      if (dl > 0) begin
         rx[7:0] = (dl == 4) ? {rx[3:0], o_io} : (dl == 2) ? {rx[5:0], o_io[1:0]} : {rx[6:0], o_io[1]};
         rx[8] = rx[8] & ((i_dev_oe_n & m) == 4'h0);
      end
      #20 if (rel) drv = 4'h0;
      #20 o_sclk = 1'b0;
   endtask
   // msb first, l lanes a clock
   task automatic send(input logic [23:0] v, input int n, input int l, input logic last);
      for (int i = n / l - 1; i >= 0; i--) begin
         drv = (l == 4) ? 4'hF : (l == 2) ? 4'h3 : 4'h1;
         val = 4'(v >> (i * l)) & drv;
         tick(last && i == 0, 0);
      end
   endtask
   // whole frame: opcode (ol 0 skips it), address, mode, dummies, data
   task automatic frame(input logic [7:0] opc, input int ol, input logic [23:0] a, input int al,
                        input int ml, input logic [7:0] m, input int nd, input int dl, input int nb);
      #1 o_cs_n = 1'b0;
      if (ol > 0) send({16'h0, opc}, 8, ol, 1'b0);
      send(a, 24, al, ml == 0);
      if (ml > 0) send({16'h0, m}, 8, ml, 1'b1);
      repeat (nd) tick(1'b0, 0);
      for (int b = 0; b < nb; b++) begin
         rx = 9'h100;
         repeat (8 / dl) tick(1'b0, dl);
         // hand over a copy: rx is cleared for the next byte before the monitor wakes
         rx_byte = rx;
         -> got;
      end
      #40 o_cs_n = 1'b1;
      #80;
   endtask
   // two clocks of all ones then deselect: lets the device see new config
   task automatic prime();
      #1 o_cs_n = 1'b0;
      drv = 4'hF;
      val = 4'hF;
      tick(1'b0, 0);
      tick(1'b1, 0);
      #40 o_cs_n = 1'b1;
      #80;
   endtask
endmodule // flash_host

// >>> dv/testbench.sv
// Purpose: self-checking bench for the flash read front end
// Assumes: array answers straight from the fetch address
// Notes:   expected bytes are queued by the driver and popped per received byte
`timescale 1ns/1ns
module testbench;
   logic        clk, rst, busy, quad_en, fourw, sclk, cs_n, fetch;
   logic [1:0]  dcnt;
   logic [3:0]  io_in, io_out, oe_n;
   logic [23:0] faddr;
   logic [7:0]  fdata;
   logic [8:0]  exp_q[$];
   int unsigned seed;
   int          errors, total_checks;
   sflash_rd_front i_sflash_rd_front (.I_CLOCK(clk), .I_RST(rst), .I_SCLK(sclk), .I_CHIP_SELECT_N(cs_n),
      .I_IO_LINE(io_in), .O_IO_LINE(io_out), .O_IO_LINE_OE_N(oe_n), .I_WRITE_IN_PROGRESS(busy),
      .I_QUAD_ENABLE(quad_en), .I_FOUR_WIRE_MODE(fourw), .I_DUMMY_COUNT_FIELD(dcnt),
      .O_ARRAY_RD(fetch), .O_ARRAY_ADDR(faddr), .I_ARRAY_DATA(fdata));
   flash_host i_flash_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(io_in), .i_dev_io(io_out), .i_dev_oe_n(oe_n));
   // array contents mix all address bytes so a wrong address shows
   function automatic logic [7:0] mem(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
   endfunction
   assign fdata = mem(faddr);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [8:0] got, input logic [8:0] want);
      total_checks++;
      if (want[8] ? got !== want : got[8] !== 1'b0) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // config change, then a short frame so the link side syncs it
   task automatic cfg(input logic b, input logic q, input logic f, input logic [1:0] d);
      @(negedge clk);
      busy <= b;
      quad_en <= q;
      fourw <= f;
      dcnt <= d;
      @(negedge clk);
      i_flash_host.prime();
   endtask
   // random start address; wl nonzero gives the wrap section length
   task automatic rd(input logic [7:0] opc, input int ol, input int al, input int ml, input logic [7:0] m,
                     input int nd, input int dl, input int nb, input logic ok, input int wl);
      logic [23:0] a, x;
      a = 24'($urandom);
      for (int j = 0; j < nb; j++) begin
         x = (wl == 0) ? a + 24'(j) : {a[23:8], (a[7:0] & ~8'(wl - 1)) | (8'(a[7:0] + 8'(j)) & 8'(wl - 1))};
         exp_q.push_back(ok ? {1'b1, mem(x)} : 9'h000);
      end
      @(negedge clk);
      i_flash_host.frame(opc, ol, a, al, ml, m, nd, dl, nb);
   endtask
   // monitor: each received byte takes the oldest note
   initial forever begin
      @(i_flash_host.got);
      check(i_flash_host.rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : 9'h1xx);
   end
   initial begin
      #400000;
      errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      results();
   end
   initial begin
      errors = 0;
      total_checks = 0;
      {rst, busy, quad_en, fourw, dcnt} = 6'h20;
      seed = $urandom(32'h41850262);
      repeat (16) @(posedge clk);
      @(negedge clk) rst <= 1'b0;
      cfg(1'b0, 1'b0, 1'b0, 2'h0);
      rd(sflash_rd_pkg::OPC_READ, 1, 1, 0, 8'h00, 0, 1, 4, 1'b1, 0);
      rd(sflash_rd_pkg::OPC_FAST, 1, 1, 0, 8'h00, 8, 1, 3, 1'b1, 0);
      rd(sflash_rd_pkg::OPC_DUAL_OUT, 1, 1, 0, 8'h00, 8, 2, 3, 1'b1, 0);
      rd(sflash_rd_pkg::OPC_QUAD_OUT, 1, 1, 0, 8'h00, 8, 4, 1, 1'b0, 0);
      cfg(1'b1, 1'b0, 1'b0, 2'h0);
      rd(sflash_rd_pkg::OPC_READ, 1, 1, 0, 8'h00, 0, 1, 1, 1'b0, 0);
      $display("test single-line reads done");
      cfg(1'b0, 1'b1, 1'b0, 2'h0);
      rd(sflash_rd_pkg::OPC_QUAD_OUT, 1, 1, 0, 8'h00, 8, 4, 3, 1'b1, 0);
      rd(sflash_rd_pkg::OPC_DUAL_IO, 1, 2, 2, 8'h2F, 0, 2, 2, 1'b1, 0);
      rd(sflash_rd_pkg::OPC_DUAL_IO, 0, 2, 2, 8'hFF, 0, 2, 2, 1'b1, 0);
      rd(sflash_rd_pkg::OPC_DUAL_IO, 1, 2, 2, 8'h00, 0, 2, 2, 1'b1, 0);
      rd(sflash_rd_pkg::OPC_QUAD_IO, 1, 4, 4, 8'hA5, 4, 4, 3, 1'b1, 0);
      rd(sflash_rd_pkg::OPC_QUAD_IO, 0, 4, 4, 8'hFF, 4, 4, 3, 1'b1, 0);
      rd(sflash_rd_pkg::OPC_QUAD_IO, 1, 4, 4, 8'h00, 4, 4, 2, 1'b1, 0);
      $display("test dual and quad reads done");
      for (int k = 0; k < 4; k++) begin
         @(negedge clk);
         i_flash_host.frame(sflash_rd_pkg::OPC_SET_WRAP, 1, 24'h0, 4, 4, {1'b1, 2'(k), 5'h0F}, 0, 0, 0);
         rd(sflash_rd_pkg::OPC_QUAD_IO, 1, 4, 4, 8'h00, 4, 4, (8 << k) + 3, 1'b1, 8 << k);
      end
      $display("test wrapped reads done");
      cfg(1'b0, 1'b1, 1'b1, 2'h0);
      rd(sflash_rd_pkg::OPC_READ, 4, 4, 0, 8'h00, 0, 4, 1, 1'b0, 0);
      for (int d = 0; d < 4; d++) begin
         cfg(1'b0, 1'b1, 1'b1, 2'(d));
         rd(sflash_rd_pkg::OPC_QUAD_IO, 4, 4, 4, 8'h00, 2 * d, 4, 66, 1'b1, 0);
         rd(sflash_rd_pkg::OPC_FAST, 4, 4, 0, 8'h00, 2 * d + 2, 4, 2, 1'b1, 0);
      end
      $display("test four-wire reads done");
      check({1'b1, 8'(exp_q.size())}, 9'h100);
      results();
   end
endmodule // testbench
